// ---- core/svc_pkg.sv ----
/*
  constants, state encoding and the state record of the supervisor
  configuration block; assumes a 20 MHz system clock.
*/
package svc_pkg;
  // slave byte preambles and fixed addresses
  localparam logic [3:0] PRE_CTRL  = 4'hb;
  localparam logic [3:0] PRE_ARRAY = 4'ha;
  localparam logic [1:0] DEV_SEL   = 2'h0;
  localparam logic [8:0] CTRL_ADDR = 9'h1ff;
  // threshold command byte addresses
  localparam logic [7:0] TRIP_UP1  = 8'h01;
  localparam logic [7:0] TRIP_UP2  = 8'h09;
  localparam logic [7:0] TRIP_UP3  = 8'h0d;
  localparam logic [7:0] TRIP_RST1 = 8'h03;
  localparam logic [7:0] TRIP_RST2 = 8'h0b;
  localparam logic [7:0] TRIP_RST3 = 8'h0f;
  // control register data patterns
  localparam logic [7:0] CMD_CLEAR = 8'h00;
  localparam logic [7:0] CMD_WEL   = 8'h02;
  localparam logic [7:0] CMD_BOTH  = 8'h06;
  // control register field positions
  localparam int POS_DLY_HI = 7;
  localparam int POS_DOG_HI = 6;
  localparam int POS_DOG_LO = 5;
  localparam int POS_LOCK   = 4;
  localparam int POS_ZERO   = 3;
  localparam int POS_RWL    = 2;
  localparam int POS_WEL    = 1;
  localparam int POS_DLY_LO = 0;
  // factory image of the retained bits
  localparam logic [7:0] FACTORY_IMAGE = 8'h61;
  // select codes and their meanings
  localparam logic [1:0] DOG_OFF    = 2'h3;
  localparam logic [10:0] DOG_MS_0  = 11'h578;
  localparam logic [10:0] DOG_MS_1  = 11'h0c8;
  localparam logic [10:0] DOG_MS_2  = 11'h019;
  localparam logic [9:0] DLY_MS_0   = 10'h032;
  localparam logic [9:0] DLY_MS_1   = 10'h0c8;
  localparam logic [9:0] DLY_MS_2   = 10'h190;
  localparam logic [9:0] DLY_MS_3   = 10'h320;
  // non-volatile store time
  localparam int CLK_HZ       = 20000000;
  localparam int NV_WRITE_MS  = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    S_IDLE, S_DEV, S_ADR, S_WR, S_ACK, S_TX, S_MACK, S_IGN
  } svc_state_t;

  typedef struct packed {
    svc_state_t  st;
    svc_state_t  nxt;
    logic [3:0]  bitCnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [8:0]  addr;
    logic [7:0]  data;
    logic [1:0]  dataCnt;
    logic        isCtrl;
    logic        hvFrame;
    logic        sdaDrv;
    logic        write_enable_latch;
    logic        register_write_latch;
    logic [1:0]  dogSel;
    logic [1:0]  dlySel;
    logic        lock;
    logic [17:0] busyCnt;
    logic        tripAct;
    logic [1:0]  tripSel;
    logic        tripRst;
    logic        tripDone;
    logic        nvStb;
    logic        arrStb;
    logic        sclPrev;
    logic        sdaPrev;
  } svc_regs_t;
endpackage : svc_pkg

// ---- core/svc_sync2.sv ----
/*
  two flip-flop synchroniser for a group of asynchronous levels;
  assumes synchronous active-low reset on the receiving clock.
*/
`timescale 1ns/1ps
module svc_sync2 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } svc_sync_t;

  svc_sync_t stage_q;
  svc_sync_t stage_d;

  // first stage feeds only the second
  always_comb begin
    stage_d.meta = din;
    stage_d.held = stage_q.meta;
  end

  // reset to the idle level so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage_q <= {INIT, INIT};
    end else begin
      stage_q <= stage_d;
    end
  end

  assign dout = stage_q.held;
endmodule : svc_sync2

// ---- core/svc_config_regs.sv ----
/*
  two-wire slave holding the supervisor control register, the
  enable latches and the threshold programming commands.
  assumes scl/sda/qualifier pins are asynchronous, the retained
  image comes from non-volatile cells, clk_sys is 20 MHz.
*/
// Summary of operation
// - STOP starts programming, pin low finishes
// - reset threshold at 03h, 0Bh, 0Fh
// - register needs 1011 preamble, address 1FFh
// - register changes only by single-byte write
// - second data byte is not acknowledged
// - stop launches non-volatile store
// - random read returns register, one byte
// - register write needs register latch set
// - write latch clear after power-up
// - latch clear: writes ignored, no acknowledge, except 02h and the threshold commands
// - writing 02h sets write latch
// - latch holds until cleared or power-up
// - latch-only writes start no store
// - lock protects 100h to 1FFh writes
// - delay select codes 50/200/400/800 ms
// - lock and period bits survive power loss
// - period select 1.4s/200ms/25ms/off
// - store clears register write latch
`timescale 1ns/1ps
module svc_config_regs
  import svc_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        sclPin,
  input  wire logic        sdaPin,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        progVoltageHi,
  input  wire logic        dogPinLow,
  input  wire logic [7:0]  nvRetained,
  output logic [7:0]       controlImage,
  output logic [1:0]       dogPeriodSel,
  output logic [10:0]      dogPeriodMs,
  output logic             dogDisabled,
  output logic [1:0]       resetDelaySel,
  output logic [9:0]       resetDelayMs,
  output logic             upperHalfLock,
  output logic             writeEnableLatch,
  output logic             registerWriteLatch,
  output logic             nvStoreStb,
  output logic             nvBusy,
  output logic             tripProgActive,
  output logic [1:0]       tripSel,
  output logic             tripReset,
  output logic             tripDoneStb,
  output logic             arrayWrStb,
  output logic [8:0]       arrayAddr,
  output logic [7:0]       arrayData
);
  svc_regs_t  q, d, rstVal;
  logic [1:0] busSync, auxSync;
  logic       scl, sda, hv, dogLow;
  logic       sclR, sclF, startC, stopC;
  logic       tripHit, tripIsRst, locked, ackOk;
  logic [1:0] tripIdx;

  // bus pins idle high, so their stages start high
  svc_sync2 #(.W(2), .INIT(2'h3)) uBus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({sclPin, sdaPin}),
    .dout    (busSync)
  );
  svc_sync2 #(.W(2), .INIT(2'h0)) uAux (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({progVoltageHi, dogPinLow}),
    .dout    (auxSync)
  );
  assign scl    = busSync[1];
  assign sda    = busSync[0];
  assign hv     = auxSync[1];
  assign dogLow = auxSync[0];

  // bus events seen on the sampled lines
  assign sclR   = scl & ~q.sclPrev;
  assign sclF   = ~scl & q.sclPrev;
  assign startC = scl & q.sclPrev & q.sdaPrev & ~sda;
  assign stopC  = scl & q.sclPrev & ~q.sdaPrev & sda;
  assign locked = q.lock & q.addr[8];

  // threshold command decode on the byte address
  always_comb begin
    tripHit   = 1'b1;
    tripIdx   = 2'h0;
    tripIsRst = (q.addr[7:0] == TRIP_RST1) || (q.addr[7:0] == TRIP_RST2) ||
                (q.addr[7:0] == TRIP_RST3);
    case (q.addr[7:0])
      TRIP_UP1:  tripIdx = 2'h1;
      TRIP_UP2:  tripIdx = 2'h2;
      TRIP_UP3:  tripIdx = 2'h3;
      TRIP_RST1: tripIdx = 2'h1;
      TRIP_RST2: tripIdx = 2'h2;
      TRIP_RST3: tripIdx = 2'h3;
      default:   tripHit = 1'b0;
    endcase
    // only A0h in a qualified frame programs
    tripHit = tripHit & q.hvFrame & ~q.isCtrl & ~q.addr[8];
  end

  // acknowledge for a received data byte
  always_comb begin
    if (q.dataCnt != 2'h0) begin
      ackOk = 1'b0;
    end else if (tripHit) begin
      ackOk = (q.sh == CMD_CLEAR);
    end else if (q.isCtrl) begin
      ackOk = q.write_enable_latch | (q.sh == CMD_WEL);
    end else begin
      ackOk = q.write_enable_latch & ~locked;
    end
  end

  // retained bits come back from the cells at power-up
  always_comb begin
    rstVal         = '0;
    rstVal.st      = S_IDLE;
    rstVal.nxt     = S_IDLE;
    rstVal.sclPrev = 1'b1;
    rstVal.sdaPrev = 1'b1;
    rstVal.dogSel  = nvRetained[POS_DOG_HI:POS_DOG_LO];
    rstVal.dlySel  = {nvRetained[POS_DLY_HI], nvRetained[POS_DLY_LO]};
    rstVal.lock    = nvRetained[POS_LOCK];
  end

  // next state of the whole block
  always_comb begin
    d          = q;
    d.sclPrev  = scl;
    d.sdaPrev  = sda;
    d.nvStb    = 1'b0;
    d.arrStb   = 1'b0;
    d.tripDone = 1'b0;
    if (q.busyCnt != 18'h0) begin
      d.busyCnt = q.busyCnt - 18'h1;
    end
    // pin pulled low closes a programming run
    if (q.tripAct && dogLow) begin
      d.tripAct  = 1'b0;
      d.tripDone = 1'b1;
    end
    if (startC) begin
      d.st      = S_DEV;
      d.bitCnt  = 4'h0;
      d.sdaDrv  = 1'b0;
      d.dataCnt = 2'h0;
      d.hvFrame = hv;
    end else if (stopC) begin
      d.st     = S_IDLE;
      d.sdaDrv = 1'b0;
      // only a single accepted data byte commits
      if (q.st == S_WR && q.dataCnt == 2'h1) begin
        if (tripHit) begin
          d.tripAct = 1'b1;
          d.tripSel = tripIdx;
          d.tripRst = tripIsRst;
        end else if (q.isCtrl) begin
          if (q.register_write_latch && !q.data[POS_RWL]) begin
            // store retained fields; bit 3 dropped
            d.dogSel  = q.data[POS_DOG_HI:POS_DOG_LO];
            d.dlySel  = {q.data[POS_DLY_HI], q.data[POS_DLY_LO]};
            d.lock    = q.data[POS_LOCK];
            d.register_write_latch    = 1'b0;
            d.nvStb   = 1'b1;
            d.busyCnt = 18'(NV_WRITE_CYCLES);
          end else if (q.data == CMD_WEL) begin
            d.write_enable_latch = 1'b1; // volatile, no busy time
          end else if (q.data == CMD_CLEAR) begin
            d.write_enable_latch = 1'b0;
          end else if (q.data == CMD_BOTH && q.write_enable_latch) begin
            d.register_write_latch = 1'b1; // bit 2 set with latch held: fields untouched
          end
        end else begin
          d.arrStb = 1'b1;
        end
      end else if (q.st == S_IGN && !q.isCtrl && q.write_enable_latch && locked &&
                   q.dataCnt == 2'h1) begin
        d.register_write_latch = 1'b0; // protected write attempt drops it
      end
    end else begin
      case (q.st)
        S_DEV, S_ADR, S_WR: begin
          if (sclR) begin
            d.sh     = {q.sh[6:0], sda};
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclF && q.bitCnt == 4'h8) begin
            d.bitCnt = 4'h0;
            d.st     = S_IGN;
            if (q.st == S_DEV) begin
              // busy or programming: stay off the bus
              if (q.sh[3:2] == DEV_SEL && q.busyCnt == 18'h0 &&
                  !q.tripAct &&
                  (q.sh[7:4] == PRE_CTRL || q.sh[7:4] == PRE_ARRAY)) begin
                d.isCtrl  = (q.sh[7:4] == PRE_CTRL);
                d.addr[8] = q.sh[1];
                d.sdaDrv  = 1'b1;
                d.st      = S_ACK;
                d.nxt     = S_ADR;
                if (q.sh[0]) begin
                  d.nxt = S_TX;
                  d.tx  = 8'hff;
                  if (q.sh[7:4] == PRE_CTRL &&
                      {q.sh[1], q.addr[7:0]} == CTRL_ADDR) begin
                    d.tx = controlImage;
                  end
                end
              end
            end else if (q.st == S_ADR) begin
              d.addr[7:0] = q.sh;
              if (!q.isCtrl || {q.addr[8], q.sh} == CTRL_ADDR) begin
                d.sdaDrv = 1'b1;
                d.st     = S_ACK;
                d.nxt    = S_WR;
              end
            end else begin
              d.data = q.sh;
              if (q.dataCnt != 2'h3) begin
                d.dataCnt = q.dataCnt + 2'h1;
              end
              if (ackOk) begin
                d.sdaDrv = 1'b1;
                d.st     = S_ACK;
                d.nxt    = S_WR;
              end
            end
          end
        end
        S_ACK: begin
          // release ack, or put the first read bit out
          if (sclF) begin
            d.st     = q.nxt;
            d.sdaDrv = (q.nxt == S_TX) ? ~q.tx[7] : 1'b0;
          end
        end
        S_TX: begin
          if (sclR) begin
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (sclF) begin
            if (q.bitCnt == 4'h8) begin
              d.bitCnt = 4'h0;
              d.sdaDrv = 1'b0;
              d.st     = S_MACK;
            end else begin
              d.tx     = {q.tx[6:0], 1'b1};
              d.sdaDrv = ~q.tx[6];
            end
          end
        end
        S_MACK: begin
          // one byte per read, whatever the master answers
          if (sclR) begin
            d.st = S_IGN;
          end
        end
        default: d.st = q.st;
      endcase
    end
  end

  // latches start cleared, retained bits reloaded
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= rstVal;
    end else begin
      q <= d;
    end
  end

  // period and delay decode
  always_comb begin
    case (q.dlySel)
      2'h0:    resetDelayMs = DLY_MS_0;
      2'h1:    resetDelayMs = DLY_MS_1;
      2'h2:    resetDelayMs = DLY_MS_2;
      default: resetDelayMs = DLY_MS_3;
    endcase
    case (q.dogSel)
      2'h0:    dogPeriodMs = DOG_MS_0;
      2'h1:    dogPeriodMs = DOG_MS_1;
      2'h2:    dogPeriodMs = DOG_MS_2;
      default: dogPeriodMs = 11'h000;
    endcase
  end

  // register image, bit 3 hard zero
  assign controlImage = {q.dlySel[1], q.dogSel, q.lock, 1'b0,
                         q.register_write_latch, q.write_enable_latch, q.dlySel[0]};
  assign sdaOut             = 1'b0;
  assign sdaOe              = q.sdaDrv;
  assign dogPeriodSel       = q.dogSel;
  assign dogDisabled        = (q.dogSel == DOG_OFF);
  assign resetDelaySel      = q.dlySel;
  assign upperHalfLock      = q.lock;
  assign writeEnableLatch   = q.write_enable_latch;
  assign registerWriteLatch = q.register_write_latch;
  assign nvStoreStb         = q.nvStb;
  assign nvBusy             = (q.busyCnt != 18'h0);
  assign tripProgActive     = q.tripAct;
  assign tripSel            = q.tripSel;
  assign tripReset          = q.tripRst;
  assign tripDoneStb        = q.tripDone;
  assign arrayWrStb         = q.arrStb;
  assign arrayAddr          = q.addr;
  assign arrayData          = q.data;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  second_nack_a: assert property (
    (q.st == S_WR && sclF && q.bitCnt == 4'h8 && q.dataCnt != 2'h0)
      |=> !sdaOe && q.st == S_IGN)
    else $error("second data byte acknowledged");
  wel_gate_a: assert property (
    (q.st == S_WR && sclF && !startC && !stopC && q.bitCnt == 4'h8 &&
     !q.write_enable_latch && !tripHit && q.sh != CMD_WEL) |=> !sdaOe)
    else $error("write acknowledged with latch clear");
  store_clr_a: assert property (
    $rose(nvBusy) |-> !registerWriteLatch && $past(registerWriteLatch))
    else $error("store without register latch or latch kept");
  nv_hold_a: assert property (
    ($changed(dogPeriodSel) || $changed(upperHalfLock) ||
     $changed(resetDelaySel)) |->
      nvStoreStb && $past(q.register_write_latch))
    else $error("retained bits changed without store");
  lock_a: assert property (
    arrayWrStb |-> !(upperHalfLock && arrayAddr[8]) && $past(q.write_enable_latch))
    else $error("protected or disabled array write");
  trip_end_a: assert property (
    tripDoneStb |-> $past(tripProgActive) && !tripProgActive)
    else $error("programming ended without active run");
  wel_quick_a: assert property (
    $rose(writeEnableLatch) |-> !nvBusy && !nvStoreStb)
    else $error("latch write started a store");
  zero_bit_a: assert property (
    controlImage[POS_ZERO] == 1'b0 && controlImage[POS_RWL] == q.register_write_latch)
    else $error("control image bit wrong");
  one_byte_a: assert property (
    (q.st == S_MACK && sclR && !startC && !stopC) |=> q.st == S_IGN)
    else $error("read continued past one byte");

  store_c: cover property (nvStoreStb);
  trip_c:  cover property (tripDoneStb && tripReset);
  read_c:  cover property (q.st == S_MACK && sclR);
endmodule : svc_config_regs

// ---- tb/svc_bus_master.sv ----
/*
  two-wire bus master model that stands on the processor side of the block.
  assumes the design samples the pins with clk_sys; scl stands high between
  frames, data is open drain with a pull-up.
*/
`timescale 1ns/1ps
module svc_bus_master (
  input  wire logic clk_sys,
  input  wire logic sdaOe,
  input  wire logic sdaOut,
  output logic      sclPin,
  output logic      sdaPin
);
  logic mLow;
  // second byte for the abort case, any value does
  localparam logic [7:0] CMD_BOTH_M = 8'h06;

  initial begin
    sclPin = 1'b1;
    mLow = 1'b0;
  end

  // wired-and with pull-up: released line reads high, never a stale value
  assign sdaPin = ~(mLow | (sdaOe & ~sdaOut));

  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w

  // one 400 ns bit: data moves mid-low, sampled just before scl falls
  task automatic bitx(input logic d, output logic s);
    w(2);
    mLow <= ~d;
    w(2);
    sclPin <= 1'b1;
    w(4);
    s = sdaPin;
    sclPin <= 1'b0;
  endtask : bitx

  // start or repeated start
  task automatic start();
    w(2);
    mLow <= 1'b0;
    w(2);
    sclPin <= 1'b1;
    w(4);
    mLow <= 1'b1;
    w(4);
    sclPin <= 1'b0;
  endtask : start

  task automatic stop();
    w(2);
    mLow <= 1'b1;
    w(2);
    sclPin <= 1'b1;
    w(4);
    mLow <= 1'b0;
    w(6);
  endtask : stop

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : send

  // one data byte per frame, an optional second one only on request
  task automatic xfer(input logic [7:0] sl, input logic [7:0] ad,
                      input logic [7:0] dt, input logic two,
                      output logic [3:0] a);
    start();
    send(sl, a[3]);
    send(ad, a[2]);
    send(dt, a[1]);
    a[0] = 1'b0;
    if (two) send(CMD_BOTH_M, a[0]);
    stop();
  endtask : xfer

  // random read of the control register, one byte, then no-ack and stop
  task automatic rd_ctrl(output logic [7:0] v);
    logic s;
    start();
    send(8'hb2, s);
    send(8'hff, s);
    start();
    send(8'hb3, s);
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      v[i] = s;
    end
    bitx(1'b1, s);
    stop();
  endtask : rd_ctrl
endmodule : svc_bus_master

// ---- tb/supervisor_config_register_tb.sv ----
/*
  self-checking bench for the supervisor configuration block.
  assumes svc_bus_master as the far side and 20 MHz clk_sys.
*/
`timescale 1ns/1ps
module supervisor_config_register_tb;
  import svc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        sclPin, sdaPin, sdaOut, sdaOe;
  logic        progVoltageHi, dogPinLow, dogDisabled, upperHalfLock;
  logic [7:0]  nvRetained, controlImage, arrayData, v, r;
  logic [1:0]  dogPeriodSel, resetDelaySel, tripSel;
  logic [10:0] dogPeriodMs;
  logic [9:0]  resetDelayMs;
  logic [8:0]  arrayAddr;
  logic        writeEnableLatch, registerWriteLatch, nvStoreStb, nvBusy;
  logic        tripProgActive, tripReset, tripDoneStb, arrayWrStb;
  logic        nvSeen, trSeen, arSeen, clrQ;
  logic [3:0]  a;
  logic [31:0] seed = 32'h3a0b;
  logic [7:0]  tbl [6];
  int          mismatches = 0;
  int          totalChecks = 0;
  int          cycles = 0;

  always #25 clk_sys = ~clk_sys;

  svc_config_regs #(.NV_WRITE_CYCLES(20)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclPin(sclPin), .sdaPin(sdaPin),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .progVoltageHi(progVoltageHi),
    .dogPinLow(dogPinLow), .nvRetained(nvRetained),
    .controlImage(controlImage), .dogPeriodSel(dogPeriodSel),
    .dogPeriodMs(dogPeriodMs), .dogDisabled(dogDisabled),
    .resetDelaySel(resetDelaySel), .resetDelayMs(resetDelayMs),
    .upperHalfLock(upperHalfLock), .writeEnableLatch(writeEnableLatch),
    .registerWriteLatch(registerWriteLatch), .nvStoreStb(nvStoreStb),
    .nvBusy(nvBusy), .tripProgActive(tripProgActive), .tripSel(tripSel),
    .tripReset(tripReset), .tripDoneStb(tripDoneStb),
    .arrayWrStb(arrayWrStb), .arrayAddr(arrayAddr), .arrayData(arrayData));

  svc_bus_master m (.clk_sys(clk_sys), .sdaOe(sdaOe), .sdaOut(sdaOut),
                    .sclPin(sclPin), .sdaPin(sdaPin));

  // sticky copies of one-cycle strobes; one-cycle pulses are easy to miss
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    nvSeen <= clrQ ? 1'b0 : nvSeen | nvStoreStb;
    trSeen <= clrQ ? 1'b0 : trSeen | tripDoneStb;
    arSeen <= clrQ ? 1'b0 : arSeen | arrayWrStb;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [10:0] dog_ms(input logic [1:0] s);
    case (s)
      2'h0: return DOG_MS_0;
      2'h1: return DOG_MS_1;
      2'h2: return DOG_MS_2;
      default: return 11'h000;
    endcase
  endfunction : dog_ms

  function automatic logic [9:0] dly_ms(input logic [1:0] s);
    case (s)
      2'h0: return DLY_MS_0;
      2'h1: return DLY_MS_1;
      2'h2: return DLY_MS_2;
      default: return DLY_MS_3;
    endcase
  endfunction : dly_ms

  // image after a load or store: bit 3 and register latch read zero
  function automatic logic [7:0] keep(input logic [7:0] x, input logic w);
    return {x[7:4], 1'b0, 1'b0, w, x[0]};
  endfunction : keep

  task automatic chk(input logic [34:0] g, input logic [34:0] e);
    totalChecks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic fields(input logic [7:0] e);
    chk({controlImage, dogPeriodSel, dogPeriodMs, dogDisabled,
         resetDelaySel, resetDelayMs, upperHalfLock},
        {e, e[6:5], dog_ms(e[6:5]), e[6:5] == DOG_OFF, e[7], e[0],
         dly_ms({e[7], e[0]}), e[4]});
  endtask : fields

  task automatic clr();
    @(posedge clk_sys) clrQ <= 1'b1;
    @(posedge clk_sys) clrQ <= 1'b0;
  endtask : clr

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    progVoltageHi = 1'b0;
    dogPinLow = 1'b0;
    clrQ = 1'b0;
    nvRetained = FACTORY_IMAGE | 8'h0e;
    tbl = '{TRIP_RST1, TRIP_UP1, TRIP_RST2, TRIP_UP2, TRIP_RST3, TRIP_UP3};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    clr();
    repeat (5) @(posedge clk_sys);
    fields(keep(nvRetained, 1'b0));
    m.xfer(8'hb2, 8'hff, CMD_BOTH, 1'b0, a);
    chk(35'(a), 35'hc);
    m.xfer(8'ha0, 8'h20, 8'h5a, 1'b0, a);
    chk(35'({a, arSeen}), 35'h18);
    m.xfer(8'hb0, 8'hff, CMD_WEL, 1'b0, a);
    chk(35'({a, writeEnableLatch}), 35'h10);
    m.xfer(8'hb2, 8'hff, CMD_WEL, 1'b0, a);
    chk(35'({a, writeEnableLatch, nvSeen, nvBusy}), 35'h74);
    m.xfer(8'hb2, 8'hff, CMD_CLEAR, 1'b0, a);
    chk(35'({a, writeEnableLatch}), 35'h1c);
    for (int k = 0; k < 3; k++) begin
      m.xfer(8'hb2, 8'hff, CMD_WEL, 1'b0, a);
      m.xfer(8'hb2, 8'hff, CMD_BOTH, 1'b0, a);
      chk(35'(registerWriteLatch), 35'h1);
      seed = lfsr(seed);
      v = (seed[7:0] & 8'hfb) | 8'h08 | ((k == 2) ? 8'h10 : 8'h00);
      clr();
      m.xfer(8'hb2, 8'hff, v, 1'b0, a);
      chk(35'({a, nvSeen}), 35'h1d);
      fields(keep(v, 1'b1));
      repeat (25) @(posedge clk_sys);
      m.rd_ctrl(r);
      chk(35'(r), 35'(keep(v, 1'b1)));
    end
    clr();
    m.xfer(8'hb2, 8'hff, CMD_WEL, 1'b1, a);
    chk(35'(a), 35'he);
    m.xfer(8'hb2, 8'hff, 8'h90, 1'b0, a);
    chk(35'(nvSeen), 35'h0);
    fields(keep(v, 1'b1));
    m.xfer(8'ha2, 8'h00, 8'h5a, 1'b0, a);
    chk(35'({a, arSeen}), 35'h18);
    m.xfer(8'ha0, 8'h20, 8'h5a, 1'b0, a);
    chk(35'({a, arSeen, arrayAddr, arrayData}),
        35'({4'he, 1'b1, 9'h020, 8'h5a}));
    for (int i = 0; i < 6; i++) begin
      clr();
      progVoltageHi <= 1'b1;
      m.xfer(8'ha0, tbl[i], 8'h00, 1'b0, a);
      chk(35'({a, tripProgActive, tripSel, tripReset, arSeen}),
          35'({4'he, 1'b1, 2'(i / 2 + 1), ~i[0], 1'b0}));
      progVoltageHi <= 1'b0;
      dogPinLow <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk(35'({trSeen, tripProgActive}), 35'h2);
      progVoltageHi <= 1'b0;
      dogPinLow <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    clr();
    m.xfer(8'ha0, TRIP_UP1, 8'h00, 1'b0, a);
    chk(35'({arSeen, tripProgActive}), 35'h2);
    seed = lfsr(seed);
    rst_n <= 1'b0;
    nvRetained <= seed[7:0];
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    fields(keep(seed[7:0], 1'b0));
    give_verdict();
  end
endmodule : supervisor_config_register_tb
